//--- hw/pcm_pkg.sv
// Constants, field layouts and helper functions for the configuration mirror
package pcm_pkg;

    // ------------------------------------------------------------
    // Register select codes on the configuration write port
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_COMMAND = 3'h0;
    localparam logic [2:0] SEL_DEV_STATUS = 3'h1;
    localparam logic [2:0] SEL_DEV_CONTROL = 3'h2;
    localparam logic [2:0] SEL_LINK_CONTROL = 3'h3;
    localparam logic [2:0] SEL_DEV_CONTROL2 = 3'h4;
    localparam logic [2:0] SEL_LINK_STATUS = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_IO_DECODE = 0;
    localparam int CMD_MEM_DECODE = 1;
    localparam int CMD_BUS_MASTER = 2;
    localparam int CMD_PARITY_ERR = 6;
    localparam int CMD_SYSTEM_ERROR = 8;
    localparam int CMD_INT_DISABLE = 10;
    localparam int DST_AUX_POWER = 4;
    localparam int DST_TXN_PENDING = 5;
    localparam int LST_RESERVED = 10;
    localparam int LST_WIDTH_LSB = 4;
    localparam int LCT_RETRAIN = 5;
    localparam int DCT_RESERVED = 15;
    localparam int DST_ERR_FLAGS = 4;
    localparam int LST_BW_FLAGS = 2;

    // ------------------------------------------------------------
    // Writable masks and hardwired-zero masks
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_WMASK = 16'h0507;
    localparam logic [15:0] CMD_HARDWIRED = 16'h02B8;
    localparam logic [15:0] DST_W1C_MASK = 16'h000F;
    localparam logic [15:0] DST_RESERVED = 16'hFFC0;
    localparam logic [15:0] DCT_WMASK = 16'h7FFF;
    localparam logic [15:0] LCT_WMASK = 16'h0FFB;
    localparam logic [15:0] LCT_WMASK_EP = 16'h0FDB;
    localparam logic [15:0] LCT_RESERVED = 16'hF004;
    localparam logic [15:0] LST_W1C_MASK = 16'hC000;
    localparam logic [15:0] DC2_WMASK = 16'h001F;
    localparam logic [15:0] DC2_RESERVED = 16'hFFE0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Expand two byte enables into a sixteen bit lane mask
    function automatic logic [15:0] be_mask(input logic [1:0] be);
        be_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    // Merge a write into a register; only enabled, writable bits change
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] data,
                                          input logic [1:0] be,
                                          input logic [15:0] wmask);
        logic [15:0] m;
        m = be_mask(be) & wmask;
        merge = (old_v & ~m) | (data & m);
    endfunction : merge

endpackage : pcm_pkg

//--- hw/pcm_sticky_bank.sv
// Bank of hardware-set, write-one-to-clear status flags
`timescale 1ns/100ps
module pcm_sticky_bank #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } pcm_sticky_s;

    pcm_sticky_s s_r;
    pcm_sticky_s s_nxt;

    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("pcm_sticky_bank: WIDTH out of range");
        end
    end

    // A set in the same cycle as its clear wins, so no event is lost
    always_comb begin
        s_nxt = s_r;
        s_nxt.flags = (s_r.flags & ~clr_in) | set_in;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign flags = s_r.flags;

    set_wins_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        (set_in != '0) |=> ((flags & $past(set_in)) == $past(set_in)))
        else $error("sticky flag lost a set event");

endmodule : pcm_sticky_bank

//--- hw/pcm_config_mirror.sv
// Configuration register mirror with inbound decode gating
`timescale 1ns/100ps
// ------------------------------------------------------------
// Overview of operation
// [RL1] Command mirror: interrupt, system error, decode enables
// [RL2] Command bits 9,7,5,4,3 held at zero
// [RL3] Parity error enable unsupported, reads zero
// [RL4] User sends requests only with bus master
// [RL5] Inbound memory/io accepted only when enabled
// [RL6] Host config writes update decode enables
// [RL7] Device status: pending and four error flags
// [RL8] Aux power detected always reads zero
// [RL9] Device control: read request, payload codes
// [RL10] Device control single-bit enables and reporting
// [RL11] Link status bandwidth, active, slot, training
// [RL12] Link status width and speed fields
// [RL13] Link control fields, reserved bits zero
// [RL14] Retrain bit reserved on an endpoint
// [RL15] User avoids retrain during L1 negotiation
// [RL16] Device control 2 timeout disable and range
// [RL17] Reserved bits zero, control writes visible next cycle, status clears two cycles later
// ------------------------------------------------------------
module pcm_config_mirror #(
    parameter bit IS_ENDPOINT = 1'b1,
    parameter bit SLOT_CLOCK_CFG = 1'b1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cfg_wr_valid,
    input wire logic [2:0] cfg_wr_sel,
    input wire logic [15:0] cfg_wr_data,
    input wire logic [1:0] cfg_wr_be,
    input wire logic txn_pending_in,
    input wire logic err_corr_event,
    input wire logic err_nonfatal_event,
    input wire logic err_fatal_event,
    input wire logic err_ur_event,
    input wire logic link_training_in,
    input wire logic dll_active_in,
    input wire logic [5:0] link_width_in,
    input wire logic [3:0] link_speed_in,
    input wire logic bw_mgmt_event,
    input wire logic auton_bw_event,
    input wire logic rx_mem_req,
    input wire logic rx_io_req,
    output logic [15:0] header_command_mirror,
    output logic [15:0] device_status_mirror,
    output logic [15:0] device_control_mirror,
    output logic [15:0] link_status_mirror,
    output logic [15:0] link_control_mirror,
    output logic [15:0] device_control2_mirror,
    output logic rx_mem_accept,
    output logic rx_io_accept,
    output logic rx_req_reject
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] dstat;
        logic [15:0] dctl;
        logic [15:0] lstat;
        logic [15:0] lctl;
        logic [15:0] dctl2;
        logic mem_acc;
        logic io_acc;
        logic rej;
    } pcm_mirror_s;

    pcm_mirror_s s_r;
    pcm_mirror_s s_nxt;

    logic [pcm_pkg::DST_ERR_FLAGS-1:0] dev_err_set;
    logic [pcm_pkg::DST_ERR_FLAGS-1:0] dev_err_clr;
    logic [pcm_pkg::DST_ERR_FLAGS-1:0] dev_err_flags;
    logic [pcm_pkg::LST_BW_FLAGS-1:0] bw_set;
    logic [pcm_pkg::LST_BW_FLAGS-1:0] bw_clr;
    logic [pcm_pkg::LST_BW_FLAGS-1:0] bw_flags;
    logic [15:0] wr_lanes;
    logic [15:0] lct_wmask;

    initial begin
        if (IS_ENDPOINT !== 1'b0 && IS_ENDPOINT !== 1'b1) begin
            $error("pcm_config_mirror: IS_ENDPOINT must be 0 or 1");
        end
    end

    // ------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------
    assign wr_lanes = pcm_pkg::be_mask(cfg_wr_be) & cfg_wr_data;
    assign dev_err_set = {err_ur_event, err_fatal_event, err_nonfatal_event, err_corr_event};
    // [RL7] Error flags cleared by one
    assign dev_err_clr = (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_DEV_STATUS) ?
        wr_lanes[pcm_pkg::DST_ERR_FLAGS-1:0] : '0;
    assign bw_set = {auton_bw_event, bw_mgmt_event};
    // [RL11] Bandwidth flags cleared by one
    assign bw_clr = (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_LINK_STATUS) ?
        wr_lanes[15:14] : '0;

    pcm_sticky_bank #(
        .WIDTH(pcm_pkg::DST_ERR_FLAGS)
    ) u_dev_err (
        .core_clk(core_clk),
        .reset(reset),
        .set_in(dev_err_set),
        .clr_in(dev_err_clr),
        .flags(dev_err_flags)
    );

    pcm_sticky_bank #(
        .WIDTH(pcm_pkg::LST_BW_FLAGS)
    ) u_bw (
        .core_clk(core_clk),
        .reset(reset),
        .set_in(bw_set),
        .clr_in(bw_clr),
        .flags(bw_flags)
    );

    // [RL14] Retrain not writable on endpoint
    assign lct_wmask = IS_ENDPOINT ? pcm_pkg::LCT_WMASK_EP : pcm_pkg::LCT_WMASK;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // [RL7] Device status assembly
        // [RL8] Aux power bit zero
        s_nxt.dstat = {10'h000, txn_pending_in, 1'b0, dev_err_flags};
        // [RL11] Link status flags
        // [RL12] Width and speed fields
        s_nxt.lstat = {bw_flags, dll_active_in, SLOT_CLOCK_CFG, link_training_in, 1'b0,
                       link_width_in, link_speed_in};
        // [RL6] Host writes update registers
        // [RL17] Masks keep reserved bits zero
        if (cfg_wr_valid) begin
            case (cfg_wr_sel)
                // [RL1] Command writable bits
                // [RL2] Hardwired bits excluded
                // [RL3] Parity enable excluded
                pcm_pkg::SEL_COMMAND: begin
                    s_nxt.cmd = pcm_pkg::merge(s_r.cmd, cfg_wr_data, cfg_wr_be,
                                               pcm_pkg::CMD_WMASK);
                end
                // [RL9] Size code fields
                // [RL10] Single-bit enables
                pcm_pkg::SEL_DEV_CONTROL: begin
                    s_nxt.dctl = pcm_pkg::merge(s_r.dctl, cfg_wr_data, cfg_wr_be,
                                                pcm_pkg::DCT_WMASK);
                end
                // [RL13] Link control fields
                pcm_pkg::SEL_LINK_CONTROL: begin
                    s_nxt.lctl = pcm_pkg::merge(s_r.lctl, cfg_wr_data, cfg_wr_be, lct_wmask);
                end
                // [RL16] Timeout disable and range
                pcm_pkg::SEL_DEV_CONTROL2: begin
                    s_nxt.dctl2 = pcm_pkg::merge(s_r.dctl2, cfg_wr_data, cfg_wr_be,
                                                 pcm_pkg::DC2_WMASK);
                end
                default: begin
                    s_nxt.cmd = s_r.cmd;
                end
            endcase
        end
        // [RL5] Decode enable gating
        // Gating uses the registered enables, matching what the user sees
        s_nxt.mem_acc = rx_mem_req & s_r.cmd[pcm_pkg::CMD_MEM_DECODE];
        s_nxt.io_acc = rx_io_req & s_r.cmd[pcm_pkg::CMD_IO_DECODE];
        s_nxt.rej = (rx_mem_req & ~s_r.cmd[pcm_pkg::CMD_MEM_DECODE]) |
                    (rx_io_req & ~s_r.cmd[pcm_pkg::CMD_IO_DECODE]);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // [RL4] Bus master bit visible to user
    assign header_command_mirror = s_r.cmd;
    assign device_status_mirror = s_r.dstat;
    assign device_control_mirror = s_r.dctl;
    assign link_status_mirror = s_r.lstat;
    assign link_control_mirror = s_r.lctl;
    assign device_control2_mirror = s_r.dctl2;
    assign rx_mem_accept = s_r.mem_acc;
    assign rx_io_accept = s_r.io_acc;
    assign rx_req_reject = s_r.rej;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    cmd_reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset) // [RL1]
        (header_command_mirror & ~pcm_pkg::CMD_WMASK) == 16'h0000)
        else $error("command reserved bit set");

    cmd_hardwired_zero_a: assert property (@(posedge core_clk) disable iff (reset) // [RL2]
        (header_command_mirror & pcm_pkg::CMD_HARDWIRED) == 16'h0000)
        else $error("command hardwired bit set");

    parity_unsupported_a: assert property (@(posedge core_clk) disable iff (reset) // [RL3]
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_COMMAND) |=>
        !header_command_mirror[pcm_pkg::CMD_PARITY_ERR])
        else $error("parity enable became set");

    mem_gating_a: assert property (@(posedge core_clk) disable iff (reset) // [RL5]
        (rx_mem_req && !header_command_mirror[pcm_pkg::CMD_MEM_DECODE] && !rx_io_req) |=>
        (!rx_mem_accept && rx_req_reject))
        else $error("memory request accepted while decode disabled");

    io_gating_a: assert property (@(posedge core_clk) disable iff (reset) // [RL5]
        (rx_io_req && header_command_mirror[pcm_pkg::CMD_IO_DECODE]) |=> rx_io_accept)
        else $error("enabled io request not accepted");

    cmd_write_next_a: assert property (@(posedge core_clk) disable iff (reset) // [RL6]
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_COMMAND && cfg_wr_be[0]) |=>
        (header_command_mirror[2:0] == $past(cfg_wr_data[2:0])))
        else $error("command write not visible next cycle");

    dstat_reserved_a: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
        (device_status_mirror & pcm_pkg::DST_RESERVED) == 16'h0000)
        else $error("device status reserved bit set");

    err_event_seen_a: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
        err_fatal_event |-> ##2 device_status_mirror[2])
        else $error("fatal error event not reported");

    aux_power_zero_a: assert property (@(posedge core_clk) disable iff (reset) // [RL8]
        !device_status_mirror[pcm_pkg::DST_AUX_POWER])
        else $error("aux power detected not zero");

    dctl_write_a: assert property (@(posedge core_clk) disable iff (reset) // [RL10]
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_DEV_CONTROL && cfg_wr_be == 2'h3) |=>
        (device_control_mirror == ($past(cfg_wr_data) & pcm_pkg::DCT_WMASK)))
        else $error("device control write mismatch");

    dctl_reserved_a: assert property (@(posedge core_clk) disable iff (reset) // [RL9]
        !device_control_mirror[pcm_pkg::DCT_RESERVED])
        else $error("device control bit 15 set");

    lstat_reserved_a: assert property (@(posedge core_clk) disable iff (reset) // [RL11]
        !link_status_mirror[pcm_pkg::LST_RESERVED])
        else $error("link status bit 10 set");

    lstat_track_a: assert property (@(posedge core_clk) disable iff (reset) // [RL12]
        ##1 (link_status_mirror[9:0] == {$past(link_width_in), $past(link_speed_in)}))
        else $error("link width or speed not tracking");

    lctl_reserved_a: assert property (@(posedge core_clk) disable iff (reset) // [RL13]
        (link_control_mirror & pcm_pkg::LCT_RESERVED) == 16'h0000)
        else $error("link control reserved bit set");

    retrain_ep_a: assert property (@(posedge core_clk) disable iff (reset) // [RL14]
        IS_ENDPOINT |-> !link_control_mirror[pcm_pkg::LCT_RETRAIN])
        else $error("retrain bit set on endpoint");

    dctl2_reserved_a: assert property (@(posedge core_clk) disable iff (reset) // [RL16]
        (device_control2_mirror & pcm_pkg::DC2_RESERVED) == 16'h0000)
        else $error("device control 2 reserved bit set");

    dctl2_write_a: assert property (@(posedge core_clk) disable iff (reset) // [RL17]
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_DEV_CONTROL2 && cfg_wr_be[0]) |=>
        (device_control2_mirror[4:0] == $past(cfg_wr_data[4:0])))
        else $error("device control 2 write not visible next cycle");

    dstat_clear_a: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_DEV_STATUS && cfg_wr_be[0] &&
        cfg_wr_data[0] && !err_corr_event) |-> ##2 !device_status_mirror[0])
        else $error("correctable error flag not cleared");

    pending_track_a: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
        ##1 (device_status_mirror[pcm_pkg::DST_TXN_PENDING] == $past(txn_pending_in)))
        else $error("transaction pending not tracking");

    io_reject_a: assert property (@(posedge core_clk) disable iff (reset) // [RL5]
        (rx_io_req && !header_command_mirror[pcm_pkg::CMD_IO_DECODE]) |=> rx_req_reject)
        else $error("disabled io request not rejected");

    bw_event_seen_a: assert property (@(posedge core_clk) disable iff (reset) // [RL11]
        bw_mgmt_event |-> ##2 link_status_mirror[14])
        else $error("bandwidth management event not reported");

    bw_clear_a: assert property (@(posedge core_clk) disable iff (reset) // [RL11]
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_LINK_STATUS && cfg_wr_be[1] &&
        cfg_wr_data[14] && !bw_mgmt_event) |-> ##2 !link_status_mirror[14])
        else $error("bandwidth management flag not cleared");

    cmd_write_c: cover property (@(posedge core_clk) disable iff (reset)
        (cfg_wr_valid && cfg_wr_sel == pcm_pkg::SEL_COMMAND) ##1
        header_command_mirror[pcm_pkg::CMD_BUS_MASTER]);

    mem_accept_c: cover property (@(posedge core_clk) disable iff (reset) rx_mem_accept);

    reject_c: cover property (@(posedge core_clk) disable iff (reset) rx_req_reject);

    io_accept_c: cover property (@(posedge core_clk) disable iff (reset) rx_io_accept);

    err_clear_c: cover property (@(posedge core_clk) disable iff (reset)
        device_status_mirror[0] ##1 (dev_err_clr[0]) ##2 !device_status_mirror[0]);

endmodule : pcm_config_mirror

//--- tb/pcm_user_model.sv
// Behavioural model of the user application logic beside the mirror
`timescale 1ns/100ps
module pcm_user_model #(
    parameter logic [2:0] L1_NEGOTIATING = 3'h5
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] header_command_mirror,
    input wire logic [2:0] link_power_state,
    input wire logic want_req,
    input wire logic want_cpl,
    input wire logic want_retrain,
    output logic tx_req,
    output logic tx_cpl,
    output logic retrain_wr
);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_req <= 1'b0;
            tx_cpl <= 1'b0;
            retrain_wr <= 1'b0;
        end else begin
            tx_req <= want_req & header_command_mirror[pcm_pkg::CMD_BUS_MASTER];
            // Completions go out whatever the bus master bit says
            tx_cpl <= want_cpl;
            retrain_wr <= want_retrain & (link_power_state != L1_NEGOTIATING);
        end
    end
endmodule : pcm_user_model

//--- tb/pcie_config_status_mirror_tb_top.sv
// Self-checking bench for the configuration mirror and its user-side model
`timescale 1ns/100ps
module pcie_config_status_mirror_tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cfg_wr_valid = 1'b0;
    logic [2:0] cfg_wr_sel = 3'h0;
    logic [15:0] cfg_wr_data = 16'h0000;
    logic [1:0] cfg_wr_be = 2'h0;
    logic [3:0] err_ev = 4'h0;
    logic [1:0] bw_ev = 2'h0;
    logic txn_pending_in = 1'b0;
    logic link_training_in = 1'b0;
    logic dll_active_in = 1'b0;
    logic [5:0] link_width_in = 6'h00;
    logic [3:0] link_speed_in = 4'h0;
    logic rx_mem_req = 1'b0;
    logic rx_io_req = 1'b0;
    logic [2:0] link_power_state = 3'h0;
    logic want_req = 1'b0;
    logic want_cpl = 1'b0;
    logic want_retrain = 1'b0;
    logic [15:0] cmd_m, dst_m, dct_m, lst_m, lct_m, dc2_m;
    logic mem_acc, io_acc, rej, tx_req, tx_cpl, retrain_wr;
    int errors = 0;
    int n_checks = 0;

    always #4 core_clk = ~core_clk;

    pcm_config_mirror #(.IS_ENDPOINT(1'b1), .SLOT_CLOCK_CFG(1'b1)) dut (
        .core_clk(core_clk), .reset(reset), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_sel(cfg_wr_sel), .cfg_wr_data(cfg_wr_data), .cfg_wr_be(cfg_wr_be),
        .txn_pending_in(txn_pending_in), .err_corr_event(err_ev[0]),
        .err_nonfatal_event(err_ev[1]), .err_fatal_event(err_ev[2]), .err_ur_event(err_ev[3]),
        .link_training_in(link_training_in), .dll_active_in(dll_active_in),
        .link_width_in(link_width_in), .link_speed_in(link_speed_in),
        .bw_mgmt_event(bw_ev[0]), .auton_bw_event(bw_ev[1]), .rx_mem_req(rx_mem_req),
        .rx_io_req(rx_io_req), .header_command_mirror(cmd_m), .device_status_mirror(dst_m),
        .device_control_mirror(dct_m), .link_status_mirror(lst_m),
        .link_control_mirror(lct_m), .device_control2_mirror(dc2_m),
        .rx_mem_accept(mem_acc), .rx_io_accept(io_acc), .rx_req_reject(rej));

    pcm_user_model u_user (
        .core_clk(core_clk), .reset(reset), .header_command_mirror(cmd_m),
        .link_power_state(link_power_state), .want_req(want_req), .want_cpl(want_cpl),
        .want_retrain(want_retrain), .tx_req(tx_req), .tx_cpl(tx_cpl), .retrain_wr(retrain_wr));

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        n_checks++;
        if (seen !== expv) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(negedge core_clk);
    endtask : ticks

    // Called at a falling edge; returns in the cycle where the mirror shows a control write; status clears show a cycle later
    // One idle edge first, so valid never falls and rises in one time step
    task automatic cfg_write(input logic [2:0] sel, input logic [15:0] data, input logic [1:0] be);
        ticks(1);
        cfg_wr_valid = 1'b1;
        cfg_wr_sel = sel;
        cfg_wr_data = data;
        cfg_wr_be = be;
        ticks(1);
        cfg_wr_valid = 1'b0;
    endtask : cfg_write

    task automatic t_command();
        cfg_write(pcm_pkg::SEL_COMMAND, 16'hFFFF, 2'h3);
        check(cmd_m, 16'h0507);
        check(cmd_m & 16'h02B8, 16'h0000);
        check({15'h0000, cmd_m[6]}, 16'h0000);
        cfg_write(pcm_pkg::SEL_COMMAND, 16'h0000, 2'h1);
        check(cmd_m, 16'h0500);
        cfg_write(3'h6, 16'hFFFF, 2'h3);
        check(cmd_m, 16'h0500);
    endtask : t_command

    task automatic t_decode();
        for (int i = 0; i < 4; i++) begin
            cfg_write(pcm_pkg::SEL_COMMAND, {14'h0000, i[1:0]}, 2'h1);
            rx_mem_req = 1'b1;
            rx_io_req = 1'b1;
            ticks(1);
            rx_mem_req = 1'b0;
            rx_io_req = 1'b0;
            check({13'h0000, mem_acc, io_acc, rej}, {13'h0000, i[1], i[0], ~&i[1:0]});
            ticks(1);
            check({13'h0000, mem_acc, io_acc, rej}, 16'h0000);
        end
    endtask : t_decode

    task automatic t_dev_status();
        txn_pending_in = 1'b1;
        err_ev = 4'hF;
        ticks(1);
        err_ev = 4'h0;
        ticks(1);
        check(dst_m, 16'h002F);
        cfg_write(pcm_pkg::SEL_DEV_STATUS, 16'h0005, 2'h1);
        ticks(1);
        check(dst_m, 16'h002A);
        txn_pending_in = 1'b0;
        cfg_write(pcm_pkg::SEL_DEV_STATUS, 16'hFFFF, 2'h3);
        ticks(1);
        check(dst_m, 16'h0000);
    endtask : t_dev_status

    task automatic t_controls();
        cfg_write(pcm_pkg::SEL_DEV_CONTROL, 16'hFFFF, 2'h3);
        check(dct_m, 16'h7FFF);
        cfg_write(pcm_pkg::SEL_DEV_CONTROL, 16'h0000, 2'h2);
        check(dct_m, 16'h00FF);
        cfg_write(pcm_pkg::SEL_LINK_CONTROL, 16'hFFFF, 2'h3);
        check(lct_m, 16'h0FDB);
        cfg_write(pcm_pkg::SEL_LINK_CONTROL, 16'h0020, 2'h1);
        check(lct_m, 16'h0F00);
        cfg_write(pcm_pkg::SEL_DEV_CONTROL2, 16'hFFFF, 2'h3);
        check(dc2_m, 16'h001F);
        cfg_write(pcm_pkg::SEL_DEV_CONTROL2, 16'h0007, 2'h1);
        check(dc2_m, 16'h0007);
    endtask : t_controls

    task automatic t_link_status();
        link_training_in = 1'b1;
        dll_active_in = 1'b1;
        link_width_in = 6'h2A;
        link_speed_in = 4'h5;
        bw_ev = 2'h3;
        ticks(1);
        bw_ev = 2'h0;
        ticks(1);
        check(lst_m, 16'hFAA5);
        cfg_write(pcm_pkg::SEL_LINK_STATUS, 16'h4FFF, 2'h3);
        ticks(1);
        check(lst_m, 16'hBAA5);
        link_training_in = 1'b0;
        dll_active_in = 1'b0;
        link_width_in = 6'h15;
        link_speed_in = 4'h2;
        ticks(2);
        check(lst_m, 16'h9152);
    endtask : t_link_status

    task automatic t_partner();
        cfg_write(pcm_pkg::SEL_COMMAND, 16'h0000, 2'h3);
        want_req = 1'b1;
        want_cpl = 1'b1;
        ticks(1);
        check({14'h0000, tx_req, tx_cpl}, 16'h0001);
        cfg_write(pcm_pkg::SEL_COMMAND, 16'h0004, 2'h1);
        ticks(1);
        check({14'h0000, tx_req, tx_cpl}, 16'h0003);
        want_req = 1'b0;
        want_cpl = 1'b0;
        link_power_state = 3'h5;
        want_retrain = 1'b1;
        ticks(1);
        check({15'h0000, retrain_wr}, 16'h0000);
        link_power_state = 3'h0;
        ticks(1);
        check({15'h0000, retrain_wr}, 16'h0001);
        want_retrain = 1'b0;
    endtask : t_partner

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        ticks(2);
        check(cmd_m | dst_m | dct_m | lst_m | lct_m | dc2_m, 16'h0000);
        reset = 1'b0;
        ticks(2);
        t_command();
        t_decode();
        t_dev_status();
        t_controls();
        t_link_status();
        t_partner();
        test_done();
    end

    // The tests need about 61 cycles; this span is well beyond that
    initial begin
        #20000;
        errors++;
        test_done();
    end
endmodule : pcie_config_status_mirror_tb_top
